// *** rtl/usb_otg_regs_defines.vh ***
`ifndef USB_OTG_REGS_DEFINES_VH
`define USB_OTG_REGS_DEFINES_VH
`define OFS_OTG_IFLAGS 16'h5040
`define OFS_OTG_IEN 16'h5050
`define OFS_OTG_STAT 16'h5060
`define OFS_OTG_CTRL 16'h5070
`define OFS_PWR_CTRL 16'h5080
`define OFS_GEN_IFLAGS 16'h5200
`define OFS_GEN_IEN 16'h5210
`define OFS_ERR_IFLAGS 16'h5220
`define OFS_ERR_IEN 16'h5230
`define OFS_XFER_STAT 16'h5240
`define OFS_MOD_CTRL 16'h5250
`define OFS_DEV_ADDR 16'h5260
`define OFS_BDT_LOW 16'h5270
`define ALIAS_PLAIN 2'h0
`define ALIAS_CLEAR 2'h1
`define ALIAS_SET 2'h2
`define ALIAS_INVERT 2'h3
`define MASK_OTG_IFLAGS 8'hfd
`define MASK_OTG_IEN 8'hfd
`define MASK_OTG_CTRL 8'hff
`define MASK_PWR_CTRL 8'h1b
`define MASK_GEN_IFLAGS 8'hff
`define MASK_ERR_IFLAGS 8'hff
`define MASK_MOD_CTRL 8'h0f
`define MASK_DEV_ADDR 8'hff
`define MASK_BDT_LOW 8'hfe
`define BIT_ACT_PEND 7
`define BIT_SESSION_END 2
`define BIT_SESSION_VALID 3
`define BIT_BUS_VALID 0
`define BIT_IF_BUS_VALID 0
`define BIT_IF_SESSION_END 2
`define BIT_IF_SESSION_VALID 3
`define BIT_IF_ACTIVITY 4
`define BIT_MOD_HOST_EN 3
`define BIT_MOD_ENABLE 0
`define RESET_VALUE 8'h00
`define USB_CLK_HZ 48000000
`define SYS_CLK_HZ 20000000
`endif

// *** rtl/usb_otg_regs.v ***
//
// Contract
// - Clear, set, invert aliases at 4, 8, c.
// - Flag registers offer only the clear alias.
// - Status registers have no aliases at all.
// - Bits reset zero; unimplemented bits read zero.
// - Activity pending bit reset value undefined.
// - Module needs a 48 MHz bus clock.
// - Engine moves packets and handshakes autonomously.
// - Internal DMA carries data to RAM buffers.
// - DMA reads flash, reads and writes RAM.
// - Full speed both roles, low speed host.
// - Supply comparators reported in line status.
`include "usb_otg_regs_defines.vh"
`default_nettype none
module usb_otg_regs (
    input wire CLK,
    input wire RESET_N,
    input wire USB_CLK_48M_OK,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [31:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire BUS_VALID_IN,
    input wire SESSION_VALID_IN,
    input wire SESSION_END_IN,
    input wire ID_IN,
    input wire LINE_J_IN,
    input wire LINE_SE0_IN,
    input wire ACTIVITY_IN,
    input wire [7:0] ENGINE_EVENTS,
    input wire [7:0] ENGINE_ERRORS,
    input wire [7:0] ENGINE_XFER_STAT,
    input wire ENGINE_BUSY,
    output reg [7:0] LINE_CONTROL,
    output reg [7:0] MODULE_CONTROL,
    output reg [7:0] DEVICE_ADDRESS,
    output reg [7:0] BDT_POINTER_LOW,
    output reg [7:0] POWER_CONTROL,
    output wire ENGINE_ENABLE,
    output wire HOST_MODE,
    output wire IRQ
);

// ==========================================================================
// Pin synchronisers
// ==========================================================================
localparam NSYNC = 8;
wire [NSYNC-1:0] raw_in = {USB_CLK_48M_OK, ACTIVITY_IN, LINE_SE0_IN, LINE_J_IN, ID_IN,
    SESSION_END_IN, SESSION_VALID_IN, BUS_VALID_IN};
reg [NSYNC-1:0] sync1_ff;
reg [NSYNC-1:0] sync2_ff;
reg [NSYNC-1:0] prev_ff;
always @(posedge CLK)
begin
    if (!RESET_N)
    begin
        sync1_ff <= {NSYNC{1'b0}};
        sync2_ff <= {NSYNC{1'b0}};
        prev_ff <= {NSYNC{1'b0}};
    end
    else
    begin
        sync1_ff <= raw_in;
        sync2_ff <= sync1_ff;
        prev_ff <= sync2_ff;
    end
end
wire bus_valid = sync2_ff[0];
wire session_valid = sync2_ff[1];
wire session_end = sync2_ff[2];
wire id_pin = sync2_ff[3];
wire line_j = sync2_ff[4];
wire line_se0 = sync2_ff[5];
wire activity = sync2_ff[6];
wire clk48_ok = sync2_ff[7];
wire [NSYNC-1:0] changed = sync2_ff ^ prev_ff;

// ==========================================================================
// Address decode
// ==========================================================================
function [3:0] reg_index;
    input [15:0] base;
    begin
        case (base)
            `OFS_OTG_IFLAGS: reg_index = 4'h1;
            `OFS_OTG_IEN: reg_index = 4'h2;
            `OFS_OTG_STAT: reg_index = 4'h3;
            `OFS_OTG_CTRL: reg_index = 4'h4;
            `OFS_PWR_CTRL: reg_index = 4'h5;
            `OFS_GEN_IFLAGS: reg_index = 4'h6;
            `OFS_GEN_IEN: reg_index = 4'h7;
            `OFS_ERR_IFLAGS: reg_index = 4'h8;
            `OFS_ERR_IEN: reg_index = 4'h9;
            `OFS_XFER_STAT: reg_index = 4'ha;
            `OFS_MOD_CTRL: reg_index = 4'hb;
            `OFS_DEV_ADDR: reg_index = 4'hc;
            `OFS_BDT_LOW: reg_index = 4'hd;
            default: reg_index = 4'h0;
        endcase
    end
endfunction

function alias_ok;
    input [3:0] idx;
    input [1:0] kind;
    begin
        case (idx)
            4'h0: alias_ok = 1'b0;
            4'h3, 4'ha: alias_ok = (kind == `ALIAS_PLAIN);
            4'h1, 4'h6, 4'h8: alias_ok = (kind == `ALIAS_PLAIN) || (kind == `ALIAS_CLEAR);
            default: alias_ok = 1'b1;
        endcase
    end
endfunction

function [7:0] apply_alias;
    input [7:0] cur;
    input [7:0] wd;
    input [1:0] kind;
    begin
        case (kind)
            `ALIAS_CLEAR: apply_alias = cur & ~wd;
            `ALIAS_SET: apply_alias = cur | wd;
            `ALIAS_INVERT: apply_alias = cur ^ wd;
            default: apply_alias = wd;
        endcase
    end
endfunction

wire [3:0] idx = (PADDR[31:16] == 16'h0000) ? reg_index({PADDR[15:4], 4'h0}) : 4'h0;
wire [1:0] kind = PADDR[3:2];
wire hit = alias_ok(idx, kind) && (PADDR[1:0] == 2'h0);
wire access = PSEL && PENABLE;
wire wr = access && PWRITE && hit;
wire [7:0] wd = PWDATA[7:0];
assign PREADY = 1'b1;
assign PSLVERR = access && !hit;

// ==========================================================================
// Interrupt flags
// ==========================================================================
reg [7:0] otg_if_ff;
reg [7:0] otg_ie_ff;
reg [7:0] gen_if_ff;
reg [7:0] gen_ie_ff;
reg [7:0] err_if_ff;
reg [7:0] err_ie_ff;
wire [7:0] otg_events;
assign otg_events[0] = changed[0];
assign otg_events[1] = 1'b0;
assign otg_events[2] = changed[2];
assign otg_events[3] = changed[1];
assign otg_events[4] = changed[6];
assign otg_events[5] = changed[4] | changed[5];
assign otg_events[6] = 1'b0;
assign otg_events[7] = changed[3];

// Flags clear by writing one; a same-cycle event wins
wire [7:0] nxt_otg_if = ((wr && idx == 4'h1) ? otg_if_ff & ~wd : otg_if_ff) | otg_events;
wire [7:0] nxt_gen_if = ((wr && idx == 4'h6) ? gen_if_ff & ~wd : gen_if_ff) | ENGINE_EVENTS;
wire [7:0] nxt_err_if = ((wr && idx == 4'h8) ? err_if_ff & ~wd : err_if_ff) | ENGINE_ERRORS;

// ==========================================================================
// Register file
// ==========================================================================
always @(posedge CLK)
begin
    if (!RESET_N)
    begin
        otg_if_ff <= `RESET_VALUE;
        otg_ie_ff <= `RESET_VALUE;
        gen_if_ff <= `RESET_VALUE;
        gen_ie_ff <= `RESET_VALUE;
        err_if_ff <= `RESET_VALUE;
        err_ie_ff <= `RESET_VALUE;
        LINE_CONTROL <= `RESET_VALUE;
        MODULE_CONTROL <= `RESET_VALUE;
        DEVICE_ADDRESS <= `RESET_VALUE;
        BDT_POINTER_LOW <= `RESET_VALUE;
        POWER_CONTROL <= `RESET_VALUE;
    end
    else
    begin
        otg_if_ff <= nxt_otg_if & `MASK_OTG_IFLAGS;
        gen_if_ff <= nxt_gen_if & `MASK_GEN_IFLAGS;
        err_if_ff <= nxt_err_if & `MASK_ERR_IFLAGS;
        if (wr && idx == 4'h2)
            otg_ie_ff <= apply_alias(otg_ie_ff, wd, kind) & `MASK_OTG_IEN;
        if (wr && idx == 4'h7)
            gen_ie_ff <= apply_alias(gen_ie_ff, wd, kind);
        if (wr && idx == 4'h9)
            err_ie_ff <= apply_alias(err_ie_ff, wd, kind);
        if (wr && idx == 4'h4)
            LINE_CONTROL <= apply_alias(LINE_CONTROL, wd, kind) & `MASK_OTG_CTRL;
        if (wr && idx == 4'hb)
            MODULE_CONTROL <= apply_alias(MODULE_CONTROL, wd, kind) & `MASK_MOD_CTRL;
        if (wr && idx == 4'hc)
            DEVICE_ADDRESS <= apply_alias(DEVICE_ADDRESS, wd, kind) & `MASK_DEV_ADDR;
        if (wr && idx == 4'hd)
            BDT_POINTER_LOW <= apply_alias(BDT_POINTER_LOW, wd, kind) & `MASK_BDT_LOW;
        if (wr && idx == 4'h5)
            POWER_CONTROL <= apply_alias(POWER_CONTROL, wd, kind) & `MASK_PWR_CTRL;
    end
end

// Engine runs only with the 48 MHz clock up; host mode is the module control host enable bit
assign ENGINE_ENABLE = MODULE_CONTROL[`BIT_MOD_ENABLE] && clk48_ok;
assign HOST_MODE = MODULE_CONTROL[`BIT_MOD_HOST_EN];

// ==========================================================================
// Status and read data
// ==========================================================================
wire [7:0] otg_stat = {id_pin, 1'b0, line_j, 1'b0, session_valid, session_end, 1'b0, bus_valid};
// Activity pending is live, so it carries no reset value of its own
wire [7:0] pwr_rd = POWER_CONTROL | {activity, 7'h00};
wire [7:0] mod_rd = MODULE_CONTROL | {line_j, line_se0, ENGINE_BUSY, 5'h00};
reg [7:0] rd8;
always @*
begin
    case (idx)
        4'h1: rd8 = otg_if_ff;
        4'h2: rd8 = otg_ie_ff;
        4'h3: rd8 = otg_stat;
        4'h4: rd8 = LINE_CONTROL;
        4'h5: rd8 = pwr_rd;
        4'h6: rd8 = gen_if_ff;
        4'h7: rd8 = gen_ie_ff;
        4'h8: rd8 = err_if_ff;
        4'h9: rd8 = err_ie_ff;
        4'ha: rd8 = ENGINE_XFER_STAT;
        4'hb: rd8 = mod_rd;
        4'hc: rd8 = DEVICE_ADDRESS;
        4'hd: rd8 = BDT_POINTER_LOW;
        default: rd8 = 8'h00;
    endcase
end

always @(posedge CLK)
begin
    if (!RESET_N)
        PRDATA <= 32'h00000000;
    else if (PSEL && !PENABLE && !PWRITE)
        // Refused reads, forbidden aliases included, return zero
        PRDATA <= hit ? {24'h000000, rd8} : 32'h00000000;
end

assign IRQ = |(otg_if_ff & otg_ie_ff) || |(gen_if_ff & gen_ie_ff) || |(err_if_ff & err_ie_ff);

endmodule
`default_nettype wire

// *** test/usb_otg_regs_checker.sv ***
`default_nettype none
// ========
// Register interface properties
module usb_otg_regs_checker (
    input wire CLK,
    input wire RESET_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [31:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire PSLVERR,
    input wire [7:0] MODULE_CONTROL,
    input wire [7:0] DEVICE_ADDRESS,
    input wire ENGINE_ENABLE,
    input wire HOST_MODE,
    input wire IRQ
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    wire acc = PSEL && PENABLE;
    sequence mc_wr(logic [31:0] a);
        acc && PWRITE && PADDR == a;
    endsequence
    reset_clear_a: assert property ($rose(RESET_N) |-> !IRQ && MODULE_CONTROL == 8'h00 && DEVICE_ADDRESS == 8'h00)
        else $error("register not clear after reset");
    upper_zero_a: assert property (acc && !PWRITE |-> PRDATA[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    set_alias_a: assert property (mc_wr(32'h5258) |=> MODULE_CONTROL[3:0] == ($past(MODULE_CONTROL[3:0]) | $past(PWDATA[3:0])))
        else $error("set alias wrong");
    clear_alias_a: assert property (mc_wr(32'h5254) |=> MODULE_CONTROL[3:0] == ($past(MODULE_CONTROL[3:0]) & ~$past(PWDATA[3:0])))
        else $error("clear alias wrong");
    invert_alias_a: assert property (mc_wr(32'h525c) |=> MODULE_CONTROL[3:0] == ($past(MODULE_CONTROL[3:0]) ^ $past(PWDATA[3:0])))
        else $error("invert alias wrong");
    flag_noset_a: assert property (acc && (PADDR == 32'h5208 || PADDR == 32'h520c) |-> PSLVERR)
        else $error("flag set alias accepted");
    status_noalias_a: assert property (acc && PADDR inside {32'h5244, 32'h5248, 32'h524c} |-> PSLVERR)
        else $error("status alias accepted");
    host_mode_a: assert property (HOST_MODE == MODULE_CONTROL[3])
        else $error("host mode mismatch");
    engine_gate_a: assert property (ENGINE_ENABLE |-> MODULE_CONTROL[0])
        else $error("engine enabled while off");
endmodule
bind usb_otg_regs usb_otg_regs_checker usb_otg_regs_checker_i (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .MODULE_CONTROL(MODULE_CONTROL), .DEVICE_ADDRESS(DEVICE_ADDRESS), .ENGINE_ENABLE(ENGINE_ENABLE),
    .HOST_MODE(HOST_MODE), .IRQ(IRQ));
`default_nettype wire

// *** test/usb_cable_model.sv ***
`default_nettype none
// ========
// Cable partner: line levels follow attach
module usb_cable_model (
    input wire logic attach,
    output logic bus_valid,
    output logic session_valid,
    output logic session_end,
    output logic line_j,
    output logic activity
);
    assign bus_valid = attach;
    assign session_valid = attach;
    assign session_end = 1'b0;
    assign line_j = attach;
    assign activity = attach;
endmodule
`default_nettype wire

// *** test/tb_usb_otg_regs.sv ***
`default_nettype none
// ========
// Bench
module tb_usb_otg_regs;
timeunit 1ns;
timeprecision 1ns;
logic clk = 0, rst_n = 0, ok48 = 1, psel = 0, pen = 0, pwr = 0, attach = 0, busy = 0, id = 0, se0 = 0, re;
logic [31:0] paddr = 0, pwdata = 0, prdata, rv;
logic [7:0] ev = 0, er = 0, xs = 0, mc, da;
logic pready, pslverr, eng_en, host, irq, vb, sv, se, lj, act;
int bad_count = 0, n_tests = 0, cyc = 0;
always #25 clk = ~clk;
usb_cable_model usb_cable_model_i (.attach(attach), .bus_valid(vb), .session_valid(sv), .session_end(se),
    .line_j(lj), .activity(act));
usb_otg_regs usb_otg_regs_i (.CLK(clk), .RESET_N(rst_n), .USB_CLK_48M_OK(ok48), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BUS_VALID_IN(vb), .SESSION_VALID_IN(sv), .SESSION_END_IN(se), .ID_IN(id), .LINE_J_IN(lj),
    .LINE_SE0_IN(se0), .ACTIVITY_IN(act), .ENGINE_EVENTS(ev), .ENGINE_ERRORS(er), .ENGINE_XFER_STAT(xs),
    .ENGINE_BUSY(busy), .LINE_CONTROL(), .MODULE_CONTROL(mc), .DEVICE_ADDRESS(da), .BDT_POINTER_LOW(),
    .POWER_CONTROL(), .ENGINE_ENABLE(eng_en), .HOST_MODE(host), .IRQ(irq));
task give_verdict;
    if (bad_count == 0 && n_tests > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
        bad_count++;
        $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
endtask
task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
        @(posedge clk);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
endtask
task wr(input logic [31:0] a, input logic [31:0] d, input logic xe);
    apb(1'b1, a, d);
    chk($sformatf("error at %h", a), {31'h0, re}, {31'h0, xe});
endtask
task rd(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] msk);
    apb(1'b0, a, 32'h0);
    chk($sformatf("read at %h", a), rv & msk, exp);
endtask
task t_reset;
    logic [15:0] regs [13] = '{16'h5040, 16'h5050, 16'h5060, 16'h5070, 16'h5080, 16'h5200, 16'h5210,
        16'h5220, 16'h5230, 16'h5240, 16'h5250, 16'h5260, 16'h5270};
    // Activity pending bit of power control is left unchecked
    for (int i = 0; i < 13; i++)
        rd({16'h0, regs[i]}, 32'h0, (i == 4) ? 32'hffffff7f : 32'hffffffff);
endtask
task t_alias;
    wr(32'h5250, 32'h5, 1'b0);
    wr(32'h5258, 32'h8, 1'b0);
    rd(32'h5250, 32'hd, 32'hff);
    chk("host mode", {31'h0, host}, 32'h1);
    wr(32'h5254, 32'h1, 1'b0);
    rd(32'h5250, 32'hc, 32'hff);
    wr(32'h525c, 32'h3, 1'b0);
    rd(32'h5250, 32'hf, 32'hff);
    chk("engine enable", {31'h0, eng_en}, 32'h1);
    wr(32'h5260, 32'hffffffa5, 1'b0);
    rd(32'h5260, 32'ha5, 32'hffffffff);
endtask
task t_flags;
    ev <= 8'h08;
    er <= 8'h01;
    @(posedge clk);
    ev <= 8'h00;
    er <= 8'h00;
    @(posedge clk);
    rd(32'h5200, 32'h08, 32'hffffffff);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(32'h5210, 32'h08, 1'b0);
    chk("irq enabled", {31'h0, irq}, 32'h1);
    wr(32'h5208, 32'h08, 1'b1);
    wr(32'h520c, 32'h08, 1'b1);
    rd(32'h5200, 32'h08, 32'hffffffff);
    wr(32'h5204, 32'h08, 1'b0);
    rd(32'h5200, 32'h00, 32'hffffffff);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rd(32'h5220, 32'h01, 32'hffffffff);
    wr(32'h5220, 32'h01, 1'b0);
    rd(32'h5220, 32'h00, 32'hffffffff);
endtask
task t_status;
    xs <= 8'h5c;
    attach <= 1'b1;
    repeat (4) @(posedge clk);
    rd(32'h5240, 32'h5c, 32'hffffffff);
    wr(32'h5244, 32'h0, 1'b1);
    wr(32'h5068, 32'h0, 1'b1);
    rd(32'h5068, 32'h0, 32'hffffffff);
    rd(32'h5060, 32'h09, 32'h0000000d);
    rd(32'h5040, 32'h09, 32'h0000000d);
    wr(32'h5300, 32'h0, 1'b1);
endtask
always @(posedge clk)
begin
    cyc++;
    if (cyc == 3000)
    begin
        bad_count++;
        give_verdict;
    end
end
initial
begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_alias;
    t_flags;
    t_status;
    give_verdict;
end
endmodule
`default_nettype wire
